// ===== verilog/rfs_defs.svh
// Constants for the reference frequency selector: register indices, limits and timing.
`ifndef RFS_DEFS_SVH
`define RFS_DEFS_SVH
// Register indices; the byte address is four times the index.
`define RFS_IDX_CTRL 5'd0
`define RFS_IDX_WIDTH 5'd1
`define RFS_IDX_CENTER1 5'd2
`define RFS_IDX_JOGFREQ 5'd5
`define RFS_IDX_JOGACC 5'd6
`define RFS_IDX_JOGDEC 5'd7
`define RFS_IDX_MAXFREQ 5'd8
`define RFS_IDX_PRESET0 5'd8
`define RFS_IDX_LASTRW 5'd23
`define RFS_IDX_STAT_FREQ 5'd24
`define RFS_IDX_STAT_FLAGS 5'd25
`define RFS_IDX_STAT_PCT 5'd26
// Control register fields.
`define RFS_CTRL_LOOP_EN 0
`define RFS_CTRL_MANUAL 1
`define RFS_CTRL_KEYPAD 2
// Setting limits in 0.01 Hz or 0.01 s units.
`define RFS_MAX_FREQ 20'd50000
`define RFS_MAX_WIDTH 20'd3000
`define RFS_MAX_TIME 20'd600000
`define RFS_WHOLE_HZ 20'd100
`define RFS_MAX_FREQ_RST 20'd6000
// Jog start window.
`define RFS_JOG_WIN_MS 100
`define RFS_CLK_KHZ 25000
`define RFS_JOG_WIN_CYC (`RFS_JOG_WIN_MS * `RFS_CLK_KHZ)
// Bus answers.
`define RFS_RESP_OKAY 2'b00
`define RFS_RESP_SLVERR 2'b10
`endif

// ===== verilog/rfs_pkg.sv
// Types shared by the reference frequency selector.
`default_nettype none
package rfs_pkg;
   typedef enum logic {RFS_NORMAL, RFS_JOG_READY} rfs_mode_t;
endpackage : rfs_pkg
`default_nettype wire

// ===== verilog/rfs_top.sv
// Reference frequency selector: jump bands, preset table, loop setpoints and jog control.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_defs.svh"
// Notes on behaviour
// [RULE1] Rising into band holds at lower edge.
// [RULE2] Falling into band holds at upper edge.
// [RULE3] Overlapping bands merge into one band.
// [RULE4] Three band centres; zero centre means none.
// [RULE5] One shared width; zero disables all bands.
// [RULE6] Fifteen preset frequencies up to 500 Hz.
// [RULE7] Four-bit select code picks preset or source.
// [RULE8] Loop setpoint from upper select bits.
// [RULE9] Manual speed from lower select bits.
// [RULE10] Setpoint presets whole hertz; percent of maximum.
// [RULE11] Jog-ready terminal enters jog-ready state.
// [RULE12] Keypad combination toggles jog-ready state.
// [RULE13] Mode changes only while the drive stopped; code also takes terminal jog-ready entry during a run inside the window.
// [RULE14] Keypad jog lasts while key held.
// [RULE15] Run terminal in jog-ready starts jog.
// [RULE16] Controller pairs jog and run within 100 ms.
// [RULE17] Run before jog-ready means normal run.
// [RULE18] Jogging uses the jog reference frequency.
// [RULE19] Jogging uses jog ramp time settings.
// [RULE20] Jog reference overrides, jump bands still apply.
module rfs_top #(
   parameter int JOG_WIN_CYC = `RFS_JOG_WIN_CYC,
   parameter int DW = 20
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // AXI4-Lite register port.
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Terminal and keypad commands.
   input wire logic preset_select_weight1_in,
   input wire logic preset_select_weight2_in,
   input wire logic preset_select_weight4_in,
   input wire logic preset_select_weight8_in,
   input wire logic forward_run_input_in,
   input wire logic reverse_run_input_in,
   input wire logic jog_ready_input_in,
   input wire logic keypad_jog_combo_in,
   input wire logic keypad_fwd_key_in,
   input wire logic keypad_rev_key_in,
   // Drive state and other reference sources.
   input wire logic motor_stopped_in,
   input wire logic [DW-1:0] normal_ref_in,
   input wire logic [DW-1:0] setpoint_source_ref_in,
   input wire logic [DW-1:0] loop_output_ref_in,
   input wire logic [DW-1:0] normal_accel_time_in,
   input wire logic [DW-1:0] normal_decel_time_in,
   // Results to the drive.
   output logic [DW-1:0] freq_ref_out,
   output logic [DW-1:0] loop_setpoint_out,
   output logic [DW-1:0] setpoint_pct_out,
   output logic [DW-1:0] accel_time_out,
   output logic [DW-1:0] decel_time_out,
   output logic run_cmd_out,
   output logic run_reverse_out,
   output logic jog_ready_out,
   output logic jogging_out
);
   // ***********************************************
   // Register storage and bus slave
   // ***********************************************
   localparam int NRW = 24;
   logic [DW-1:0] cfg [0:NRW-1];
   logic aw_held, w_held;
   logic [4:0] aw_idx;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Upper bound for each writable setting; writes above it are clamped.
   function automatic logic [DW-1:0] rfs_limit(input logic [4:0] idx);
      if (idx == `RFS_IDX_WIDTH)
         rfs_limit = `RFS_MAX_WIDTH;
      else if (idx == `RFS_IDX_JOGACC || idx == `RFS_IDX_JOGDEC)
         rfs_limit = `RFS_MAX_TIME; // RULE19
      else if (idx == `RFS_IDX_CTRL)
         rfs_limit = 20'h00007;
      else
         rfs_limit = `RFS_MAX_FREQ; // RULE4 RULE6 RULE18
   endfunction : rfs_limit

   // Byte-lane merge followed by clamping to the setting's range.
   wire [DW-1:0] old_val = cfg[aw_idx];
   wire [23:0] merged = {w_strb[2] ? w_data[23:16] : {4'h0, old_val[19:16]},
                         w_strb[1] ? w_data[15:8] : old_val[15:8],
                         w_strb[0] ? w_data[7:0] : old_val[7:0]};
   wire [DW-1:0] lim = rfs_limit(aw_idx);
   wire [DW-1:0] next_val = (merged > {4'h0, lim}) ? lim : merged[DW-1:0];
   wire wr_go = aw_held && w_held && !s_axi_bvalid_out;
   wire wr_ok = aw_idx < 5'(NRW);

   // Address and data are latched independently, so either may arrive first.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 5'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr_in[7] ? 5'h1f : s_axi_awaddr_in[6:2];
         end
         else if (wr_go)
            aw_held <= 1'b0;
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         else if (wr_go)
            w_held <= 1'b0;
      end
   end

   // Ready is offered only while the corresponding holding slot is empty.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `RFS_RESP_OKAY;
      end
      else
      begin
         s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out);
         s_axi_wready_out <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out);
         if (wr_go)
         begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_ok ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
         end
         else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
      end
   end

   // Settings storage; the maximum frequency resets to a usable nonzero value.
   genvar gi;
   generate
      for (gi = 0; gi < NRW; gi++)
      begin : g_cfg
         always_ff @(posedge core_clk_in)
         begin
            if (sys_rst_in)
               cfg[gi] <= (gi == `RFS_IDX_MAXFREQ) ? `RFS_MAX_FREQ_RST : 20'h00000;
            else if (wr_go && aw_idx == 5'(gi))
               cfg[gi] <= next_val;
         end
      end
   endgenerate

   // Read side: status words expose the block's live outputs.
   wire [4:0] ar_idx = s_axi_araddr_in[6:2];
   wire [31:0] flags = {28'h0000000, run_reverse_out, run_cmd_out, jogging_out, jog_ready_out};
   wire [31:0] rd_word = (ar_idx < 5'(NRW)) ? {12'h000, cfg[ar_idx]} :
                         (ar_idx == `RFS_IDX_STAT_FREQ) ? {12'h000, freq_ref_out} :
                         (ar_idx == `RFS_IDX_STAT_FLAGS) ? flags :
                         (ar_idx == `RFS_IDX_STAT_PCT) ? {12'h000, setpoint_pct_out} : 32'h00000000;
   wire rd_ok = ar_idx <= `RFS_IDX_STAT_PCT && !s_axi_araddr_in[7];
   wire rd_take = s_axi_arvalid_in && s_axi_arready_out;

   // A read is answered one cycle after the address is taken.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
         s_axi_rresp_out <= `RFS_RESP_OKAY;
      end
      else
      begin
         s_axi_arready_out <= !s_axi_rvalid_out && !rd_take;
         if (rd_take)
         begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_ok ? rd_word : 32'h00000000;
            s_axi_rresp_out <= rd_ok ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
         end
         else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
      end
   end

   // ***********************************************
   // Reference source selection
   // ***********************************************
   wire [3:0] sel = {preset_select_weight8_in, preset_select_weight4_in,
                     preset_select_weight2_in, preset_select_weight1_in};
   wire loop_en = cfg[`RFS_IDX_CTRL][`RFS_CTRL_LOOP_EN];
   wire manual = cfg[`RFS_IDX_CTRL][`RFS_CTRL_MANUAL];
   wire keypad_src = cfg[`RFS_IDX_CTRL][`RFS_CTRL_KEYPAD];
   wire [DW-1:0] max_freq = cfg[`RFS_IDX_MAXFREQ];
   // Preset n sits at index 8+n, so code zero never reaches the table.
   wire [DW-1:0] preset_code = cfg[`RFS_IDX_PRESET0 + {1'b0, sel}]; // RULE6 RULE7
   wire [DW-1:0] preset_sp = cfg[`RFS_IDX_PRESET0 + {1'b0, sel[3:2], 2'b00}];
   wire [DW-1:0] preset_man = cfg[`RFS_IDX_PRESET0 + {3'b000, sel[1:0]}];
   // Setpoint presets count in whole hertz; fractions are dropped.
   wire [DW-1:0] sp_whole = DW'((preset_sp / `RFS_WHOLE_HZ) * `RFS_WHOLE_HZ); // RULE10
   wire [DW-1:0] setpoint = (sel[3:2] == 2'b00) ? setpoint_source_ref_in : sp_whole; // RULE8
   wire [DW-1:0] man_ref = (sel[1:0] == 2'b00) ? normal_ref_in : preset_man; // RULE9
   wire [DW-1:0] plain_ref = (sel == 4'h0) ? normal_ref_in : preset_code; // RULE7
   wire [DW-1:0] loop_ref = manual ? man_ref : loop_output_ref_in;
   wire jogging;
   wire [DW-1:0] req = jogging ? cfg[`RFS_IDX_JOGFREQ] : // RULE18 RULE20
                       (loop_en ? loop_ref : plain_ref);
   // Integer division keeps the percent exact to the next lower step; zero maximum reads zero.
   wire [31:0] pct_num = {12'h000, setpoint} * 32'd100;
   wire [DW-1:0] pct = (max_freq == 20'h00000) ? 20'h00000 : DW'(pct_num / {12'h000, max_freq}); // RULE10

   // ***********************************************
   // Jump bands
   // ***********************************************
   wire [DW-1:0] width = cfg[`RFS_IDX_WIDTH];
   wire [DW-1:0] half = width >> 1;
   logic [2:0] bvalid;
   logic [DW-1:0] blo0 [0:2];
   logic [DW-1:0] bhi0 [0:2];
   logic [DW-1:0] blo [0:2];
   logic [DW-1:0] bhi [0:2];

   // Each band is its centre plus and minus half the width.
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_band
         wire [DW-1:0] c = cfg[`RFS_IDX_CENTER1 + 5'(gi)];
         assign bvalid[gi] = (c != 20'h00000) && (width != 20'h00000); // RULE4 RULE5
         assign blo0[gi] = (c > half) ? c - half : 20'h00000;
         assign bhi0[gi] = c + half;
      end
   endgenerate

   // Two merge passes cover a chain of three overlapping bands.
   always_comb
   begin
      logic [DW-1:0] tlo [0:2];
      logic [DW-1:0] thi [0:2];
      for (int i = 0; i < 3; i++)
      begin
         tlo[i] = blo0[i];
         thi[i] = bhi0[i];
      end
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 3; i++)
            for (int j = 0; j < 3; j++)
               if (bvalid[i] && bvalid[j] && tlo[j] <= thi[i] && thi[j] >= tlo[i])
               begin
                  tlo[i] = (tlo[j] < tlo[i]) ? tlo[j] : tlo[i]; // RULE3
                  thi[i] = (thi[j] > thi[i]) ? thi[j] : thi[i]; // RULE3
               end
      for (int i = 0; i < 3; i++)
      begin
         blo[i] = tlo[i];
         bhi[i] = thi[i];
      end
   end

   // The previous output tells which side the request entered from.
   logic [DW-1:0] next_freq;
   always_comb
   begin
      next_freq = req;
      for (int i = 0; i < 3; i++)
         if (bvalid[i] && req > blo[i] && req < bhi[i])
            next_freq = (freq_ref_out >= bhi[i]) ? bhi[i] : blo[i]; // RULE1 RULE2
   end

   // ***********************************************
   // Jog control
   // ***********************************************
   rfs_pkg::rfs_mode_t mode, next_mode;
   logic jog_d, combo_d, run_d, normal_run, key_jog;
   logic [31:0] win_cnt;
   wire term_run = forward_run_input_in || reverse_run_input_in;
   wire key_any = keypad_fwd_key_in || keypad_rev_key_in;
   wire jog_rise = jog_ready_input_in && !jog_d;
   wire jog_fall = !jog_ready_input_in && jog_d;
   wire combo_rise = keypad_jog_combo_in && !combo_d;
   // A jog input paired with a fresh run input inside the window still counts.
   wire in_window = term_run && (!run_d || win_cnt < 32'(JOG_WIN_CYC)) && !normal_run; // RULE16
   wire may_switch = motor_stopped_in || in_window; // RULE13
   wire is_ready = mode == rfs_pkg::RFS_JOG_READY;
   assign jogging = is_ready && ((term_run && !normal_run) || key_jog); // RULE15 RULE14

   // Mode transitions honour the stopped condition, except jog-ready terminal entry paired with a run inside the window.
   always_comb
   begin
      next_mode = mode;
      case (mode)
         rfs_pkg::RFS_NORMAL:
            if ((jog_rise && may_switch) || (combo_rise && keypad_src && motor_stopped_in))
               next_mode = rfs_pkg::RFS_JOG_READY; // RULE11 RULE12
         rfs_pkg::RFS_JOG_READY:
            if ((jog_fall || (combo_rise && keypad_src)) && motor_stopped_in)
               next_mode = rfs_pkg::RFS_NORMAL; // RULE12 RULE13
         default:
            next_mode = rfs_pkg::RFS_NORMAL;
      endcase
   end

   // A run held past the window without jog-ready becomes an ordinary run.
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         mode <= rfs_pkg::RFS_NORMAL;
         jog_d <= 1'b0;
         combo_d <= 1'b0;
         run_d <= 1'b0;
         normal_run <= 1'b0;
         key_jog <= 1'b0;
         win_cnt <= 32'h00000000;
      end
      else
      begin
         mode <= next_mode;
         jog_d <= jog_ready_input_in;
         combo_d <= keypad_jog_combo_in;
         run_d <= term_run;
         key_jog <= keypad_src && key_any; // RULE14
         if (term_run && !run_d)
            win_cnt <= 32'h00000000;
         else if (term_run && win_cnt < 32'(JOG_WIN_CYC))
            win_cnt <= win_cnt + 32'h00000001;
         if (!term_run || jog_rise)
            normal_run <= 1'b0; // RULE17
         else if (!is_ready && !in_window)
            normal_run <= 1'b1; // RULE17
      end
   end

   // ***********************************************
   // Registered outputs
   // ***********************************************
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         freq_ref_out <= 20'h00000;
         loop_setpoint_out <= 20'h00000;
         setpoint_pct_out <= 20'h00000;
         accel_time_out <= 20'h00000;
         decel_time_out <= 20'h00000;
         run_cmd_out <= 1'b0;
         run_reverse_out <= 1'b0;
         jog_ready_out <= 1'b0;
         jogging_out <= 1'b0;
      end
      else
      begin
         freq_ref_out <= next_freq;
         loop_setpoint_out <= setpoint;
         setpoint_pct_out <= pct;
         // Jog ramps stay selected in jog-ready so a released key decelerates on the jog time.
         accel_time_out <= is_ready ? cfg[`RFS_IDX_JOGACC] : normal_accel_time_in; // RULE19
         decel_time_out <= is_ready ? cfg[`RFS_IDX_JOGDEC] : normal_decel_time_in; // RULE19 RULE14
         run_cmd_out <= jogging || normal_run;
         run_reverse_out <= key_jog ? keypad_rev_key_in : reverse_run_input_in;
         jog_ready_out <= is_ready;
         jogging_out <= jogging;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   a_jog_ref_used: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE18
      jogging && !(|bvalid) |=> freq_ref_out == $past(cfg[`RFS_IDX_JOGFREQ]))
      else $error("jog reference not used");
   a_mode_stopped: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE13
      is_ready && !motor_stopped_in |=> is_ready)
      else $error("left jog-ready while running");
   a_jog_terminal: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE11
      !is_ready && jog_rise && motor_stopped_in |=> is_ready ##1 jog_ready_out)
      else $error("jog terminal ignored");
   a_no_band_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE5
      width == 20'h00000 && !jogging |=> freq_ref_out == $past(req))
      else $error("band active with zero width");
   a_band_lower: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE1
      bvalid[0] && req > blo[0] && req < bhi[0] && freq_ref_out <= blo[0] |=> freq_ref_out == $past(blo[0]))
      else $error("band lower edge not held");
   a_band_upper: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE2
      bvalid[0] && req > blo[0] && req < bhi[0] && freq_ref_out >= bhi[0] |=> freq_ref_out == $past(bhi[0]))
      else $error("band upper edge not held");
   a_preset_pick: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE7
      !loop_en && !jogging && sel != 4'h0 && bvalid == 3'b000 |=> freq_ref_out == $past(preset_code))
      else $error("preset not selected");
   a_setpoint_pct: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE10
      max_freq != 20'h00000 |=> setpoint_pct_out * $past(max_freq) <= loop_setpoint_out * 100)
      else $error("setpoint percent wrong");
   a_key_release: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE14
      is_ready && keypad_src && !term_run && !key_any |=> ##1 !jogging_out)
      else $error("jog continued after key release");
   a_run_latched: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // RULE17
      normal_run && term_run && !jog_rise |=> !jogging)
      else $error("normal run turned into jog");
   c_jog_start: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) jog_rise ##[1:4] jogging);
   c_band_hold: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
      bvalid[0] && req > blo[0] && req < bhi[0]);
   c_keypad_toggle: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) combo_rise && keypad_src);
   c_normal_run: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) $rose(normal_run));
endmodule : rfs_top
`default_nettype wire

// ===== sim/rfs_cmd_model.sv
// Keypad and terminal command model facing the reference frequency selector.
`timescale 1ns/10ps
`default_nettype none
module rfs_cmd_model (
   // Clock.
   input wire logic clk_in,
   // Terminal and keypad levels.
   output logic [3:0] sel_out,
   output logic fwd_out,
   output logic rev_out,
   output logic jog_out,
   output logic combo_out,
   output logic kfwd_out
);
   // Every command idles low until a task asks for it.
   initial {sel_out, fwd_out, rev_out, jog_out, combo_out, kfwd_out} = '0;
   // Select code, forward run and keypad forward key, changed together.
   task automatic set_levels(input logic [3:0] s, input logic f, input logic k);
      @(posedge clk_in);
      sel_out <= s;
      fwd_out <= f;
      kfwd_out <= k;
   endtask : set_levels
   // Jog-ready first, then the run terminal; the gap stays far inside the window.
   task automatic jog_run(input logic reverse_run_input, input int gap);
      @(posedge clk_in);
      jog_out <= 1'b1;
      repeat (gap) @(posedge clk_in);
      fwd_out <= !reverse_run_input;
      rev_out <= reverse_run_input;
   endtask : jog_run
   // Drops every command but the select code at once.
   task automatic release_all();
      @(posedge clk_in);
      {fwd_out, rev_out, jog_out, combo_out, kfwd_out} <= '0;
   endtask : release_all
   // One key-combination press lasting two cycles.
   task automatic combo();
      @(posedge clk_in);
      combo_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      combo_out <= 1'b0;
   endtask : combo
endmodule : rfs_cmd_model
`default_nettype wire

// ===== sim/tb_rfs_top.sv
// Self-checking bench for the reference frequency selector.
`timescale 1ns/10ps
`default_nettype none
`include "rfs_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb_rfs_top;
   typedef struct {logic [2:0] c; logic [3:0] s; logic [19:0] f; logic [19:0] p;} rfs_row_t;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0, stop = 1;
   logic awr, wr_o, bv, arr, rvl, run, rvs, jr, jg, fw, rv, jo, cb, kf;
   logic [7:0] awa = 8'h0, ara = 8'h0;
   logic [31:0] wd = 32'h0, rdat, rd;
   logic [1:0] br, rr, r;
   logic [3:0] sel;
   logic [19:0] nref = 20'h457, sref = 20'h8ae, lref = 20'hd05, f, sp, pct, acc, dec;
   logic [19:0] breq[9] = '{20'hfa0, 20'h1388, 20'h1770, 20'h1388, 20'hfa0, 20'h1770, 20'h1900, 20'h1388, 20'hfa0};
   logic [19:0] bexp[9] = '{20'hfa0, 20'h1194, 20'h1770, 20'h157c, 20'hfa0, 20'h1194, 20'h1900, 20'h189c, 20'hfa0};
   rfs_row_t rows[24];
   int n_mismatch = 0, comparisons = 0;
   // A short jog window keeps the run brief.
   rfs_top #(.JOG_WIN_CYC(20)) dut (.core_clk_in(clk), .sys_rst_in(rst),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
      .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_o), .s_axi_bresp_out(br),
      .s_axi_bvalid_out(bv), .s_axi_bready_in(bq), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rvl),
      .s_axi_rready_in(rq), .preset_select_weight1_in(sel[0]), .preset_select_weight2_in(sel[1]),
      .preset_select_weight4_in(sel[2]), .preset_select_weight8_in(sel[3]), .forward_run_input_in(fw),
      .reverse_run_input_in(rv), .jog_ready_input_in(jo), .keypad_jog_combo_in(cb), .keypad_fwd_key_in(kf),
      .keypad_rev_key_in(1'b0), .motor_stopped_in(stop), .normal_ref_in(nref), .setpoint_source_ref_in(sref),
      .loop_output_ref_in(lref), .normal_accel_time_in(20'h11), .normal_decel_time_in(20'h22),
      .freq_ref_out(f), .loop_setpoint_out(sp), .setpoint_pct_out(pct), .accel_time_out(acc),
      .decel_time_out(dec), .run_cmd_out(run), .run_reverse_out(rvs), .jog_ready_out(jr), .jogging_out(jg));
   rfs_cmd_model term (.clk_in(clk), .sel_out(sel), .fwd_out(fw), .rev_out(rv), .jog_out(jo),
      .combo_out(cb), .kfwd_out(kf));
   // Free-running 25 MHz clock.
   always #20 clk = ~clk;
   // *****
   // Bus tasks
   // *****
   // Address and data go out together; each is dropped once its own ready is seen.
   task automatic wr(input logic [4:0] i, input logic [31:0] d, output logic [1:0] rs);
      @(posedge clk);
      awa <= {1'b0, i, 2'b00};
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bq <= 1'b1;
      fork
         begin do @(posedge clk); while (!awr); awv <= 1'b0; end
         begin do @(posedge clk); while (!wr_o); wv <= 1'b0; end
      join
      while (!bv) @(posedge clk);
      rs = br;
      bq <= 1'b0;
   endtask : wr
   // Read one word; the answer is taken at the edge that shows rvalid.
   task automatic rdr(input logic [4:0] i, output logic [31:0] d, output logic [1:0] rs);
      @(posedge clk);
      ara <= {1'b0, i, 2'b00};
      arv <= 1'b1;
      rq <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rvl);
      d = rdat;
      rs = rr;
      rq <= 1'b0;
   endtask : rdr
   // Decisions need a few edges to reach the outputs.
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask : settle
   function automatic rfs_row_t mk(logic [2:0] c, logic [3:0] s, logic [19:0] fr, logic [19:0] p);
      mk = '{c, s, fr, p};
   endfunction : mk
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   // A hung handshake is cut short here.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results();
   end
   // *****
   // Main sequence
   // *****
   initial
   begin
      for (int k = 0; k < 16; k++) rows[k] = mk(3'h0, 4'(k), k == 0 ? nref : 20'(20'h64 * k + 20'h7), 20'h0);
      rows[16] = mk(3'h1, 4'h3, lref, sref);
      for (int k = 1; k < 4; k++) rows[16 + k] = mk(3'h1, 4'(k * 5), lref, 20'(20'h190 * k));
      for (int k = 1; k < 4; k++) rows[19 + k] = mk(3'h3, 4'(k * 5), 20'(20'h64 * k + 20'h7), 20'h0);
      rows[23] = mk(3'h3, 4'hc, nref, 20'h0);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      `CHK("jog ready at reset", 1'b0, jr)
      rdr(`RFS_IDX_MAXFREQ, rd, r);
      `CHK("max freq reset", 32'h1770, rd)
      for (int n = 1; n <= 15; n++) wr(5'(`RFS_IDX_PRESET0 + n), 32'(20'h64 * n + 20'h7), r);
      rdr(5'h17, rd, r);
      `CHK("preset 15", 32'h5e3, rd)
      rdr(5'h1e, rd, r);
      `CHK("unmapped read", 2'b10, r)
      wr(5'h1e, 32'h0, r);
      `CHK("unmapped write", 2'b10, r)
      wr(`RFS_IDX_JOGFREQ, 32'h4d2, r);
      `CHK("write okay", 2'b00, r)
      wr(`RFS_IDX_JOGACC, 32'h12c, r);
      wr(`RFS_IDX_JOGDEC, 32'h190, r);
      foreach (rows[k])
      begin
         wr(`RFS_IDX_CTRL, 32'(rows[k].c), r);
         term.set_levels(rows[k].s, 1'b0, 1'b0);
         settle();
         `CHK("freq", rows[k].f, f)
         if (rows[k].c == 3'h1)
         begin
            `CHK("setpoint", rows[k].p, sp)
            `CHK("percent", 20'(rows[k].p * 20'h64 / 20'h1770), pct)
         end
      end
      // Jump bands: rising, falling, then a second band merged with the first.
      wr(`RFS_IDX_CTRL, 32'h0, r);
      term.set_levels(4'h0, 1'b0, 1'b0);
      wr(`RFS_IDX_WIDTH, 32'h3e8, r);
      wr(`RFS_IDX_CENTER1, 32'h1388, r);
      for (int k = 0; k < 9; k++)
      begin
         if (k == 5) wr(5'h3, 32'h16a8, r);
         nref <= breq[k];
         settle();
         if (k == 3 || k == 7) `CHK("band fall", bexp[k], f)
         else if (k == 5) `CHK("band merge", bexp[k], f)
         else `CHK("band rise", bexp[k], f)
      end
      wr(`RFS_IDX_WIDTH, 32'h1388, r);
      rdr(`RFS_IDX_WIDTH, rd, r);
      `CHK("width clamp", 32'hbb8, rd)
      wr(`RFS_IDX_WIDTH, 32'h0, r);
      nref <= 20'h1388;
      settle();
      `CHK("width zero", 20'h1388, f)
      wr(`RFS_IDX_WIDTH, 32'h3e8, r);
      wr(`RFS_IDX_CENTER1, 32'h0, r);
      wr(5'h3, 32'h0, r);
      settle();
      `CHK("centre zero", 20'h1388, f)
      // Terminal jog, forward then reverse.
      term.jog_run(1'b0, 3);
      settle();
      `CHK("jog ready", 1'b1, jr)
      `CHK("jogging", 1'b1, jg)
      `CHK("jog freq", 20'h4d2, f)
      `CHK("jog accel", 20'h12c, acc)
      `CHK("jog decel", 20'h190, dec)
      rdr(`RFS_IDX_STAT_FLAGS, rd, r);
      `CHK("flags", 32'h7, rd)
      term.release_all();
      settle();
      `CHK("back to normal", 1'b0, jr)
      term.jog_run(1'b1, 3);
      settle();
      `CHK("jog reverse", 1'b1, rvs)
      term.release_all();
      settle();
      // Run held past the window with no jog-ready: an ordinary run, no jog.
      term.set_levels(4'h0, 1'b1, 1'b0);
      repeat (40) @(posedge clk);
      `CHK("no jog", 1'b0, jg)
      `CHK("normal run", 1'b1, run)
      `CHK("normal freq", 20'h1388, f)
      `CHK("normal accel", 20'h11, acc)
      term.release_all();
      // Keypad: the combination is ignored while running.
      wr(`RFS_IDX_CTRL, 32'h4, r);
      stop <= 1'b0;
      term.combo();
      settle();
      `CHK("combo running", 1'b0, jr)
      stop <= 1'b1;
      term.combo();
      settle();
      `CHK("combo stopped", 1'b1, jr)
      term.set_levels(4'h0, 1'b0, 1'b1);
      settle();
      `CHK("key held", 1'b1, jg)
      term.set_levels(4'h0, 1'b0, 1'b0);
      settle();
      `CHK("key released", 1'b0, run)
      term.combo();
      settle();
      `CHK("combo toggles back", 1'b0, jr)
      results();
   end
endmodule : tb_rfs_top
`default_nettype wire
